// ===== design/rtc_params.svh
// Offsets, field positions and limits of the BCD time and calendar bank.
// Included by the day-count, counter bank and bench files; definitions only.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define OFS_SECONDS    6'h08
`define OFS_MINUTES    6'h09
`define OFS_HOURS      6'h0a
`define OFS_DAY        6'h0b
`define OFS_WEEKDAY    6'h0c
`define OFS_MONTH      6'h0d
`define OFS_YEAR       6'h0e
`define MASK_SECONDS   8'h7f
`define MASK_MINUTES   8'h7f
`define MASK_HOURS     8'h7f
`define MASK_DAY       8'h3f
`define MASK_WEEKDAY   8'h07
`define MASK_MONTH     8'h1f
`define MASK_YEAR      8'h7f
`define BIT_HOUR_MODE  6
`define BIT_PM         5
`define MAX_SEC_MIN    8'h59
`define MAX_HOUR_24    8'h23
`define MAX_HOUR_12    8'h12
`define HOUR_11        8'h11
`define MAX_WEEKDAY    8'h07
`define MAX_MONTH      8'h12
`define MAX_YEAR       8'h79
`define MONTH_FEB      8'h02
`define MIN_ONE        8'h01
`define ZERO_BYTE      8'h00
`define RESET_SECONDS  8'h00
`define RESET_MINUTES  8'h00
`define RESET_HOURS    8'h00
`define RESET_DAY      8'h01
`define RESET_WEEKDAY  8'h01
`define RESET_MONTH    8'h01
`define RESET_YEAR     8'h00
`endif

// ===== design/rtc_pkg.sv
// Types shared by the time and calendar counter bank.
// Assumes rtc_params.svh sits in the include path.
package rtc_pkg;
   typedef logic [7:0] bcd_byte_t;
   typedef logic [5:0] reg_addr_t;
endpackage

// ===== design/bcd_step.sv
// One BCD counter digit pair: increment with wrap to a minimum.
// Assumes the stored value is valid BCD within limits.
`timescale 1ns/1ps
`default_nettype none
module bcd_step
   import rtc_pkg::*;
(
   input  wire bcd_byte_t value,
   input  wire bcd_byte_t max_value,
   input  wire bcd_byte_t min_value,
   output logic [7:0]     next_value,
   output logic           wrap
);
   wire [3:0] units    = value[3:0];
   wire       unit_top = (units == 4'h9);
   wire [7:0] inc_units = {value[7:4], 4'(units + 4'h1)};
   wire [7:0] inc_tens  = {4'(value[7:4] + 4'h1), 4'h0};
   assign wrap       = (value == max_value);
   assign next_value = wrap ? min_value : (unit_top ? inc_tens : inc_units);
endmodule
`default_nettype wire

// ===== design/days_in_month.sv
// Last day of a month in BCD, with leap February.
// Assumes month and year are valid BCD values.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module days_in_month
   import rtc_pkg::*;
(
   input  wire bcd_byte_t month,
   input  wire bcd_byte_t year,
   output bcd_byte_t      last_day
);
   // BCD value divisible by four: tens parity picks units set
   wire tens_odd = year[4];
   wire [3:0] yu = year[3:0];
   wire leap = tens_odd ? (yu == 4'h2 || yu == 4'h6)
                        : (yu == 4'h0 || yu == 4'h4 || yu == 4'h8);
   wire short_month = (month == 8'h04) || (month == 8'h06) ||
                      (month == 8'h09) || (month == 8'h11);
   assign last_day = (month == `MONTH_FEB) ? (leap ? 8'h29 : 8'h28)
                   : (short_month ? 8'h30 : 8'h31);
endmodule
`default_nettype wire

// ===== design/bcd_time_calendar_counters.sv
// BCD time-of-day and calendar counter bank with byte register port.
// Assumes a one-cycle 1 Hz tick and a serial engine issuing reads/writes.
//
// Contract
// - Every counter register holds BCD: tens high, units low nibble.
// - Seconds 08h and minutes 09h use bits 6..0, values 0..59.
// - Hours 0Ah bit 6 selects 12h mode; PM bit 5 or 0..23.
// - Day 0Bh bits 5..0 hold 1..31; leap February reaches 29.
// - Year 0Eh bits 6..0 hold 0..79; multiples of 4 are leap.
// - Weekday 0Ch bits 2..0 hold 1..7, meaning chosen by software.
// - Month 0Dh bits 4..0 hold 1..12.
// - Unimplemented bits ignore writes and read back zero.
// - Counters advance only while watch enable gates the 1 Hz tick.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module bcd_time_calendar_counters
   import rtc_pkg::*;
(
   input  wire logic      core_clk,
   input  wire logic      rst_b,
   input  wire logic      tick_1hz,
   input  wire logic      watch_enable,
   input  wire reg_addr_t reg_addr,
   input  wire logic      reg_wr,
   input  wire bcd_byte_t reg_wdata,
   input  wire logic      reg_rd,
   output bcd_byte_t      reg_rdata,
   output logic           reg_rdata_valid
);
   bcd_byte_t current_seconds;
   bcd_byte_t current_minutes;
   bcd_byte_t current_hours;
   bcd_byte_t current_day_of_month;
   bcd_byte_t current_weekday;
   bcd_byte_t current_month;
   bcd_byte_t current_year;

   wire advance = tick_1hz & watch_enable;

   bcd_byte_t next_sec_cnt;
   bcd_byte_t next_min_cnt;
   logic      sec_wrap;
   logic      min_wrap;
   bcd_step u_sec (
      .value      (current_seconds),
      .max_value  (`MAX_SEC_MIN),
      .min_value  (`ZERO_BYTE),
      .next_value (next_sec_cnt),
      .wrap       (sec_wrap)
   );
   bcd_step u_min (
      .value      (current_minutes),
      .max_value  (`MAX_SEC_MIN),
      .min_value  (`ZERO_BYTE),
      .next_value (next_min_cnt),
      .wrap       (min_wrap)
   );

   wire       mode_12 = current_hours[`BIT_HOUR_MODE];
   wire       pm      = current_hours[`BIT_PM];
   wire [7:0] hour12  = {3'b000, current_hours[4:0]};
   wire [7:0] hour24  = {2'b00, current_hours[5:0]};

   bcd_byte_t next_h24;
   logic      h24_wrap;
   bcd_step u_h24 (
      .value      (hour24),
      .max_value  (`MAX_HOUR_24),
      .min_value  (`ZERO_BYTE),
      .next_value (next_h24),
      .wrap       (h24_wrap)
   );
   bcd_byte_t next_h12;
   logic      h12_wrap;
   bcd_step u_h12 (
      .value      (hour12),
      .max_value  (`MAX_HOUR_12),
      .min_value  (`MIN_ONE),
      .next_value (next_h12),
      .wrap       (h12_wrap)
   );

   // PM toggles at 11 to 12
   wire at_11      = (hour12 == `HOUR_11);
   wire next_pm    = at_11 ? ~pm : pm;
   wire day_from12 = at_11 & pm;
   wire hour_wrap  = mode_12 ? day_from12 : h24_wrap;
   wire [7:0] next_hours_cnt = mode_12
      ? {1'b0, 1'b1, next_pm, next_h12[4:0]}
      : {1'b0, 1'b0, next_h24[5:0]};

   bcd_byte_t last_day;
   days_in_month u_dim (
      .month    (current_month),
      .year     (current_year),
      .last_day (last_day)
   );
   bcd_byte_t next_day_cnt;
   logic      day_wrap;
   bcd_step u_day (
      .value      (current_day_of_month),
      .max_value  (last_day),
      .min_value  (`MIN_ONE),
      .next_value (next_day_cnt),
      .wrap       (day_wrap)
   );
   bcd_byte_t next_wday_cnt;
   bcd_step u_wday (
      .value      (current_weekday),
      .max_value  (`MAX_WEEKDAY),
      .min_value  (`MIN_ONE),
      .next_value (next_wday_cnt),
      .wrap       ()
   );
   bcd_byte_t next_mon_cnt;
   logic      mon_wrap;
   bcd_step u_mon (
      .value      (current_month),
      .max_value  (`MAX_MONTH),
      .min_value  (`MIN_ONE),
      .next_value (next_mon_cnt),
      .wrap       (mon_wrap)
   );
   bcd_byte_t next_year_cnt;
   bcd_step u_year (
      .value      (current_year),
      .max_value  (`MAX_YEAR),
      .min_value  (`ZERO_BYTE),
      .next_value (next_year_cnt),
      .wrap       ()
   );

   wire c_min  = advance & sec_wrap;
   wire c_hour = c_min & min_wrap;
   wire c_day  = c_hour & hour_wrap;
   wire c_mon  = c_day & day_wrap;
   wire c_year = c_mon & mon_wrap;

   // Host write wins over a same-cycle tick so set time is not lost
   wire w_sec  = reg_wr & (reg_addr == `OFS_SECONDS);
   wire w_min  = reg_wr & (reg_addr == `OFS_MINUTES);
   wire w_hour = reg_wr & (reg_addr == `OFS_HOURS);
   wire w_day  = reg_wr & (reg_addr == `OFS_DAY);
   wire w_wday = reg_wr & (reg_addr == `OFS_WEEKDAY);
   wire w_mon  = reg_wr & (reg_addr == `OFS_MONTH);
   wire w_year = reg_wr & (reg_addr == `OFS_YEAR);

   wire [7:0] next_seconds = w_sec ? (reg_wdata & `MASK_SECONDS)
                           : (advance ? next_sec_cnt : current_seconds);
   wire [7:0] next_minutes = w_min ? (reg_wdata & `MASK_MINUTES)
                           : (c_min ? next_min_cnt : current_minutes);
   wire [7:0] next_hours   = w_hour ? (reg_wdata & `MASK_HOURS)
                           : (c_hour ? next_hours_cnt : current_hours);
   wire [7:0] next_day     = w_day ? (reg_wdata & `MASK_DAY)
                           : (c_day ? next_day_cnt : current_day_of_month);
   wire [7:0] next_weekday = w_wday ? (reg_wdata & `MASK_WEEKDAY)
                           : (c_day ? next_wday_cnt : current_weekday);
   wire [7:0] next_month   = w_mon ? (reg_wdata & `MASK_MONTH)
                           : (c_mon ? next_mon_cnt : current_month);
   wire [7:0] next_year    = w_year ? (reg_wdata & `MASK_YEAR)
                           : (c_year ? next_year_cnt : current_year);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         current_seconds      <= `RESET_SECONDS;
         current_minutes      <= `RESET_MINUTES;
         current_hours        <= `RESET_HOURS;
         current_day_of_month <= `RESET_DAY;
         current_weekday      <= `RESET_WEEKDAY;
         current_month        <= `RESET_MONTH;
         current_year         <= `RESET_YEAR;
      end else begin
         current_seconds      <= next_seconds;
         current_minutes      <= next_minutes;
         current_hours        <= next_hours;
         current_day_of_month <= next_day;
         current_weekday      <= next_weekday;
         current_month        <= next_month;
         current_year         <= next_year;
      end
   end

   // unmapped and unused bits read zero
   wire [7:0] read_mux =
      (reg_addr == `OFS_SECONDS) ? current_seconds      :
      (reg_addr == `OFS_MINUTES) ? current_minutes      :
      (reg_addr == `OFS_HOURS)   ? current_hours        :
      (reg_addr == `OFS_DAY)     ? current_day_of_month :
      (reg_addr == `OFS_WEEKDAY) ? current_weekday      :
      (reg_addr == `OFS_MONTH)   ? current_month        :
      (reg_addr == `OFS_YEAR)    ? current_year         : `ZERO_BYTE;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata       <= `ZERO_BYTE;
         reg_rdata_valid <= 1'b0;
      end else begin
         reg_rdata       <= reg_rd ? read_mux : reg_rdata;
         reg_rdata_valid <= reg_rd;
      end
   end

   property p_no_tick_hold;
      @(posedge core_clk) disable iff (!rst_b)
      (!watch_enable && !reg_wr) |=> $stable(current_seconds);
   endproperty
   a_no_tick_hold: assert property (p_no_tick_hold)
      else $error("seconds moved without watch enable");

   property p_sec_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      (advance && !reg_wr && current_seconds == 8'h59)
      |=> current_seconds == 8'h00;
   endproperty
   a_sec_wrap: assert property (p_sec_wrap)
      else $error("seconds did not wrap to zero");

   property p_sec_range;
      @(posedge core_clk) disable iff (!rst_b)
      current_seconds[7] == 1'b0;
   endproperty
   a_sec_range: assert property (p_sec_range)
      else $error("seconds bit 7 set");

   property p_unused_zero;
      @(posedge core_clk) disable iff (!rst_b)
      current_day_of_month[7:6] == 2'b00 && current_weekday[7:3] == 5'h00
      && current_month[7:5] == 3'h0 && current_year[7] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unimplemented bit set");

   property p_pm_toggle;
      @(posedge core_clk) disable iff (!rst_b)
      (c_hour && !reg_wr && mode_12 && hour12 == 8'h11)
      |=> current_hours[4:0] == 5'h12 && current_hours[5] != $past(pm);
   endproperty
   a_pm_toggle: assert property (p_pm_toggle)
      else $error("12h step at 11 wrong");

   property p_twelve_to_one;
      @(posedge core_clk) disable iff (!rst_b)
      (c_hour && !reg_wr && mode_12 && hour12 == 8'h12)
      |=> current_hours[4:0] == 5'h01 && current_hours[6];
   endproperty
   a_twelve_to_one: assert property (p_twelve_to_one)
      else $error("12h step at 12 wrong");

   property p_leap_feb;
      @(posedge core_clk) disable iff (!rst_b)
      (c_day && !reg_wr && current_month == 8'h02
       && current_day_of_month == 8'h28 && current_year == 8'h00)
      |=> current_day_of_month == 8'h29;
   endproperty
   a_leap_feb: assert property (p_leap_feb)
      else $error("leap year 00 skipped 29th");

   property p_month_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      (c_mon && !reg_wr && current_month == 8'h12)
      |=> current_month == 8'h01 && current_year != $past(current_year);
   endproperty
   a_month_wrap: assert property (p_month_wrap)
      else $error("December rollover wrong");

   property p_read_latency;
      @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `OFS_WEEKDAY && !reg_wr)
      |=> reg_rdata_valid && reg_rdata == $past(current_weekday);
   endproperty
   a_read_latency: assert property (p_read_latency)
      else $error("weekday read mismatch");

   property p_hour_wrap24;
      @(posedge core_clk) disable iff (!rst_b)
      (c_hour && !reg_wr && !mode_12 && hour24 == `MAX_HOUR_24)
      |=> current_hours == `ZERO_BYTE
          && current_day_of_month != $past(current_day_of_month);
   endproperty
   a_hour_wrap24: assert property (p_hour_wrap24)
      else $error("24h rollover did not carry into day");

   property p_wday_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      (c_day && !reg_wr && current_weekday == `MAX_WEEKDAY)
      |=> current_weekday == `MIN_ONE;
   endproperty
   a_wday_wrap: assert property (p_wday_wrap)
      else $error("weekday did not wrap to one");

   property p_unmapped_read;
      @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && (reg_addr < `OFS_SECONDS || reg_addr > `OFS_YEAR))
      |=> reg_rdata == `ZERO_BYTE;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   property p_min_range;
      @(posedge core_clk) disable iff (!rst_b)
      current_minutes[7] == 1'b0 && current_hours[7] == 1'b0;
   endproperty
   a_min_range: assert property (p_min_range)
      else $error("minutes or hours bit 7 set");
endmodule
`default_nettype wire

// ===== dv/bcd_time_calendar_counters_bench.sv
// Bench for the BCD time and calendar counter bank.
// Drives the byte register port and the tick itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module bcd_time_calendar_counters_bench
   import rtc_pkg::*;
;
   logic      core_clk;
   logic      rst_b;
   logic      tick_1hz;
   logic      watch_enable;
   reg_addr_t reg_addr;
   logic      reg_wr;
   bcd_byte_t reg_wdata;
   logic      reg_rd;
   bcd_byte_t reg_rdata;
   logic      reg_rdata_valid;
   int        errors;
   int        n_tests;
   int        k;
   bcd_byte_t got;
   bcd_byte_t vals [7];

   bcd_time_calendar_counters uut (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .tick_1hz        (tick_1hz),
      .watch_enable    (watch_enable),
      .reg_addr        (reg_addr),
      .reg_wr          (reg_wr),
      .reg_wdata       (reg_wdata),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata),
      .reg_rdata_valid (reg_rdata_valid)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input bcd_byte_t exp,
                      input bcd_byte_t seen);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Idle cycle after each strobe so it is never re-raised in one step
   task automatic wr(input reg_addr_t a, input bcd_byte_t d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   task automatic rd(input reg_addr_t a, output bcd_byte_t d);
      int i;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      for (i = 0; i < 4 && reg_rdata_valid !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (reg_rdata_valid !== 1'b1) begin
         errors++;
         $display("wrong value read_valid expected 1 seen 0");
         final_report();
      end else begin
         d = reg_rdata;
         @(posedge core_clk);
         #1;
      end
   endtask

   task automatic tick(input logic en);
      watch_enable = en;
      tick_1hz     = 1'b1;
      @(posedge core_clk);
      #1;
      tick_1hz = 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   // Rows run seconds, minutes, hours, day, weekday, month, year
   task automatic run(input string name, input logic en,
                      input bcd_byte_t s [7], input bcd_byte_t e [7]);
      int j;
      watch_enable = 1'b0;
      for (j = 0; j < 7; j++)
         wr(reg_addr_t'(`OFS_SECONDS + j), s[j]);
      tick(en);
      for (j = 0; j < 7; j++) begin
         rd(reg_addr_t'(`OFS_SECONDS + j), got);
         chk(name, e[j], got);
      end
      $display("test %s done", name);
   endtask

   initial begin
      errors       = 0;
      n_tests      = 0;
      rst_b        = 1'b0;
      tick_1hz     = 1'b0;
      watch_enable = 1'b0;
      reg_addr     = 6'h00;
      reg_wr       = 1'b0;
      reg_wdata    = 8'h00;
      reg_rd       = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      vals = '{`RESET_SECONDS, `RESET_MINUTES, `RESET_HOURS, `RESET_DAY,
               `RESET_WEEKDAY, `RESET_MONTH, `RESET_YEAR};
      for (k = 0; k < 7; k++) begin
         rd(reg_addr_t'(`OFS_SECONDS + k), got);
         chk("reset_value", vals[k], got);
      end
      wr(6'h0f, 8'h5a);
      rd(6'h0f, got);
      chk("unmapped_0f", 8'h00, got);
      rd(6'h07, got);
      chk("unmapped_07", 8'h00, got);
      $display("test reset_and_unmapped done");
      // Unused bit positions must drop set bits; hour byte kept legal
      vals = '{8'h7f, 8'h7f, 8'h72, 8'h3f, 8'h07, 8'h1f, 8'h7f};
      for (k = 0; k < 7; k++) begin
         wr(reg_addr_t'(`OFS_SECONDS + k), (k == 2) ? 8'hf2 : 8'hff);
         rd(reg_addr_t'(`OFS_SECONDS + k), got);
         chk("field_mask", vals[k], got);
      end
      $display("test field_mask done");
      run("one_second", 1'b1,
          '{8'h05, 8'h09, 8'h12, 8'h15, 8'h01, 8'h09, 8'h20},
          '{8'h06, 8'h09, 8'h12, 8'h15, 8'h01, 8'h09, 8'h20});
      run("hour_units_carry", 1'b1,
          '{8'h59, 8'h59, 8'h09, 8'h15, 8'h01, 8'h09, 8'h20},
          '{8'h00, 8'h00, 8'h10, 8'h15, 8'h01, 8'h09, 8'h20});
      run("full_wrap", 1'b1,
          '{8'h59, 8'h59, 8'h23, 8'h31, 8'h07, 8'h12, 8'h79},
          '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
      run("watch_disabled", 1'b0,
          '{8'h59, 8'h59, 8'h23, 8'h31, 8'h07, 8'h12, 8'h79},
          '{8'h59, 8'h59, 8'h23, 8'h31, 8'h07, 8'h12, 8'h79});
      run("leap_year_00", 1'b1,
          '{8'h59, 8'h59, 8'h23, 8'h28, 8'h03, 8'h02, 8'h00},
          '{8'h00, 8'h00, 8'h00, 8'h29, 8'h04, 8'h02, 8'h00});
      run("plain_year_01", 1'b1,
          '{8'h59, 8'h59, 8'h23, 8'h28, 8'h03, 8'h02, 8'h01},
          '{8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h03, 8'h01});
      run("leap_day_end", 1'b1,
          '{8'h59, 8'h59, 8'h23, 8'h29, 8'h05, 8'h02, 8'h04},
          '{8'h00, 8'h00, 8'h00, 8'h01, 8'h06, 8'h03, 8'h04});
      run("thirty_day_month", 1'b1,
          '{8'h59, 8'h59, 8'h23, 8'h30, 8'h05, 8'h04, 8'h05},
          '{8'h00, 8'h00, 8'h00, 8'h01, 8'h06, 8'h05, 8'h05});
      run("twelve_h_11am", 1'b1,
          '{8'h59, 8'h59, 8'h51, 8'h10, 8'h02, 8'h06, 8'h10},
          '{8'h00, 8'h00, 8'h72, 8'h10, 8'h02, 8'h06, 8'h10});
      run("twelve_h_12pm", 1'b1,
          '{8'h59, 8'h59, 8'h72, 8'h10, 8'h02, 8'h06, 8'h10},
          '{8'h00, 8'h00, 8'h61, 8'h10, 8'h02, 8'h06, 8'h10});
      run("twelve_h_11pm", 1'b1,
          '{8'h59, 8'h59, 8'h71, 8'h10, 8'h02, 8'h06, 8'h10},
          '{8'h00, 8'h00, 8'h52, 8'h11, 8'h03, 8'h06, 8'h10});
      final_report();
   end
endmodule
`default_nettype wire
